// [core/prc_defines.svh]
// Purpose: constants for the photo response correction block
// Assumes: 8-bit pixels, two sensor bands, 256 pixels per band line
// Notes: the sensor width is a fixed design constant; the slot store has no reset
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

`define PRC_PIX_W 8
`define PRC_X_W 8
`define PRC_IDX_W 9
`define PRC_GAIN_W 16
`define PRC_ACC_W 18
`define PRC_SLOT_W 4
`define PRC_LCNT_W 10
`define PRC_LINES_LAST 10'h3ff
`define PRC_IDX_LAST 9'h1ff
`define PRC_MAP_DEPTH 512
`define PRC_SLOT_COUNT 16
`define PRC_AVG_LSB 10
`define PRC_GAIN_UNITY 16'h0100
`define PRC_GAIN_MAX 16'hffff
`define PRC_SCALE_RESET 16'h0100
`define PRC_DARK_RESET 8'h00

`endif

// [core/prc_pkg.sv]
// Purpose: types and shared arithmetic for the photo response correction block
// Assumes: gains and scales are unsigned q8.8
// Notes: all arithmetic saturates instead of wrapping
`include "prc_defines.svh"

package prc_pkg;

    typedef enum logic [2:0] {
        PRC_IDLE,
        PRC_ACCUM,
        PRC_MAXSCAN,
        PRC_GAIN,
        PRC_STORE,
        PRC_LOAD,
        PRC_LDONE
    } prc_state_t;

    function automatic logic [7:0] prc_mul_q88(input logic [7:0] p, input logic [15:0] g);
        logic [23:0] prod;
        prod = {16'h0000, p} * {8'h00, g};
        if (prod[23:16] != 8'h00) begin
            return 8'hff;
        end
        return prod[15:8];
    endfunction

    function automatic logic [15:0] prc_scale_q88(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] prod;
        prod = {16'h0000, a} * {16'h0000, b};
        if (prod[31:24] != 8'h00) begin
            return 16'hffff;
        end
        return prod[23:8];
    endfunction

    function automatic logic [7:0] prc_add_sat(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[8] ? 8'hff : sum[7:0];
    endfunction

endpackage

// [core/prc_slot_store.sv]
// Purpose: sixteen non-volatile gain map slots
// Assumes: one write and one read per cycle
// Notes: no reset on purpose, contents must survive it; unwritten slots read undefined
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_slot_store (
    input wire logic mclk,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [`PRC_SLOT_W-1:0] wr_slot,
    input wire logic [`PRC_IDX_W-1:0] wr_idx,
    input wire logic [`PRC_GAIN_W-1:0] wr_data,
    input wire logic [`PRC_SLOT_W-1:0] rd_slot,
    input wire logic [`PRC_IDX_W-1:0] rd_idx,
    output logic [`PRC_GAIN_W-1:0] rd_data
);

    logic [`PRC_GAIN_W-1:0] mem [`PRC_SLOT_COUNT*`PRC_MAP_DEPTH];

    // ************************************************
    // slot array
    // ************************************************
    always_ff @(posedge mclk) begin
        if (ce && wr_en) begin
            mem[{wr_slot, wr_idx}] <= wr_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (ce) begin
            rd_data <= mem[{rd_slot, rd_idx}];
        end
    end

endmodule

// [core/prc_pixel_path.sv]
// Purpose: gain multiply and window-limited coefficient correction
// Assumes: gain already chosen per pixel upstream
// Notes: one register stage; every output is a flop
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_pixel_path (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [`PRC_PIX_W-1:0] in_data,
    input wire logic in_band,
    input wire logic in_line_end,
    input wire logic [`PRC_GAIN_W-1:0] in_gain,
    input wire logic in_roi,
    input wire logic [`PRC_GAIN_W-1:0] coef_scale,
    input wire logic [`PRC_PIX_W-1:0] dark_level,
    output logic out_valid,
    output logic [`PRC_PIX_W-1:0] out_data,
    output logic out_band,
    output logic out_line_end
);

    logic [`PRC_PIX_W-1:0] gained;
    logic [`PRC_PIX_W-1:0] next_data;

    always_comb begin
        gained = prc_pkg::prc_mul_q88(in_data, in_gain);
        next_data = gained;
        if (in_roi) begin
            next_data = prc_pkg::prc_add_sat(prc_pkg::prc_mul_q88(gained, coef_scale), dark_level);
        end
    end

    // ************************************************
    // output stage
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_band <= 1'b0;
            out_line_end <= 1'b0;
        end else if (ce) begin
            out_valid <= in_valid;
            out_data <= next_data;
            out_band <= in_band;
            out_line_end <= in_line_end;
        end
    end

    a_roi_outside: assert property (@(posedge mclk) disable iff (!nrst)
        ce && in_valid && !in_roi |=> out_data == prc_pkg::prc_mul_q88($past(in_data), $past(in_gain)))
        else $error("coefficient correction leaked outside window");

endmodule

// [core/prc_top.sv]
// Purpose: per-pixel gain non-uniformity correction for a two-band line camera
// Assumes: full sensor lines arrive; pix_line_end marks the last pixel of a line
// Notes: output keeps only pixels inside the horizontal window
`timescale 1ns/1ps
`include "prc_defines.svh"

module prc_top (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic pix_valid,
    input wire logic [`PRC_PIX_W-1:0] pix_data,
    input wire logic pix_band,
    input wire logic pix_line_end,
    input wire logic response_correction_enable,
    input wire logic [`PRC_SLOT_W-1:0] gain_map_slot_select,
    input wire logic target_level_auto_select,
    input wire logic [`PRC_PIX_W-1:0] flat_field_target_level,
    input wire logic gain_map_generate_cmd,
    input wire logic gain_map_store_cmd,
    input wire logic gain_map_restore_cmd,
    input wire logic [`PRC_PIX_W-1:0] dark_offset_coefficient,
    input wire logic dark_offset_coefficient_apply,
    input wire logic [`PRC_GAIN_W-1:0] gain_map_coefficient,
    input wire logic gain_map_coefficient_apply,
    input wire logic [`PRC_X_W-1:0] horizontal_window_offset,
    input wire logic [`PRC_X_W:0] horizontal_window_width,
    input wire logic correction_window_enable,
    input wire logic [`PRC_X_W-1:0] correction_window_start,
    input wire logic [`PRC_X_W-1:0] correction_window_end,
    output logic out_valid,
    output logic [`PRC_PIX_W-1:0] out_data,
    output logic out_band,
    output logic out_line_end,
    output logic busy,
    output logic cmd_accepted,
    output logic gain_map_ready,
    output logic gain_map_active
);

    prc_pkg::prc_state_t state;
    prc_pkg::prc_state_t next_state;
    logic [`PRC_GAIN_W-1:0] work_gain [`PRC_MAP_DEPTH];
    logic [`PRC_ACC_W-1:0] acc [`PRC_MAP_DEPTH];
    logic [`PRC_IDX_W-1:0] idx;
    logic [`PRC_LCNT_W-1:0] line_cnt;
    logic [`PRC_X_W-1:0] pix_x;
    logic [`PRC_SLOT_W-1:0] op_slot;
    logic [`PRC_PIX_W-1:0] max_first;
    logic [`PRC_PIX_W-1:0] max_second;
    logic [`PRC_PIX_W-1:0] avg;
    logic [`PRC_PIX_W-1:0] tgt;
    logic [`PRC_GAIN_W-1:0] gain_calc;
    logic [`PRC_GAIN_W-1:0] store_data;
    logic [`PRC_GAIN_W-1:0] slot_rd;
    logic [`PRC_GAIN_W-1:0] coef_scale;
    logic [`PRC_PIX_W-1:0] dark_level;
    logic ld_wr;
    logic [`PRC_IDX_W-1:0] ld_widx;
    logic work_valid;
    logic in_win;
    logic in_roi;
    logic [`PRC_X_W:0] win_rel;
    logic s1_valid;
    logic [`PRC_PIX_W-1:0] s1_data;
    logic s1_band;
    logic s1_line_end;
    logic [`PRC_GAIN_W-1:0] s1_gain;
    logic s1_roi;

    // ************************************************
    // command sequencer
    // ************************************************
    always_comb begin
        next_state = state;
        case (state)
            prc_pkg::PRC_IDLE: begin
                if (gain_map_generate_cmd) begin
                    next_state = prc_pkg::PRC_ACCUM;
                end else if (gain_map_store_cmd) begin
                    next_state = prc_pkg::PRC_STORE;
                end else if (gain_map_restore_cmd) begin
                    next_state = prc_pkg::PRC_LOAD;
                end
            end
            prc_pkg::PRC_ACCUM: begin
                if (pix_valid && pix_line_end && pix_band && line_cnt == `PRC_LINES_LAST) begin
                    next_state = prc_pkg::PRC_MAXSCAN;
                end
            end
            prc_pkg::PRC_MAXSCAN: begin
                if (idx == `PRC_IDX_LAST) begin
                    next_state = prc_pkg::PRC_GAIN;
                end
            end
            prc_pkg::PRC_GAIN, prc_pkg::PRC_STORE: begin
                if (idx == `PRC_IDX_LAST) begin
                    next_state = prc_pkg::PRC_IDLE;
                end
            end
            prc_pkg::PRC_LOAD: begin
                if (idx == `PRC_IDX_LAST) begin
                    next_state = prc_pkg::PRC_LDONE;
                end
            end
            default: begin
                next_state = prc_pkg::PRC_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state <= prc_pkg::PRC_IDLE;
            busy <= 1'b0;
            cmd_accepted <= 1'b0;
            op_slot <= 4'h0;
        end else if (ce) begin
            state <= next_state;
            busy <= next_state != prc_pkg::PRC_IDLE;
            // commands seen while busy are dropped, not queued
            cmd_accepted <= state == prc_pkg::PRC_IDLE && next_state != prc_pkg::PRC_IDLE;
            if (state == prc_pkg::PRC_IDLE) begin
                op_slot <= gain_map_slot_select;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            idx <= 9'h000;
        end else if (ce) begin
            if (state == prc_pkg::PRC_IDLE || state == prc_pkg::PRC_ACCUM) begin
                idx <= 9'h000;
            end else begin
                idx <= idx + 9'h001;
            end
        end
    end

    // ************************************************
    // line accumulation over the whole sensor
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            pix_x <= 8'h00;
        end else if (ce && pix_valid) begin
            pix_x <= pix_line_end ? 8'h00 : pix_x + 8'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            line_cnt <= 10'h000;
        end else if (ce) begin
            if (state != prc_pkg::PRC_ACCUM) begin
                line_cnt <= 10'h000;
            end else if (pix_valid && pix_line_end && pix_band) begin
                line_cnt <= line_cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (ce && state == prc_pkg::PRC_ACCUM && pix_valid) begin
            // first line pair overwrites, so stale sums never leak in
            acc[{pix_band, pix_x}] <= (line_cnt == 10'h000) ? {10'h000, pix_data} :
                acc[{pix_band, pix_x}] + {10'h000, pix_data};
        end
    end

    // ************************************************
    // gain computation
    // ************************************************
    always_comb begin
        avg = acc[idx][`PRC_ACC_W-1:`PRC_AVG_LSB];
        if (target_level_auto_select) begin
            tgt = idx[8] ? max_second : max_first;
        end else begin
            tgt = flat_field_target_level;
        end
        gain_calc = (avg == 8'h00) ? `PRC_GAIN_MAX : ({tgt, 8'h00} / {8'h00, avg});
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            max_first <= 8'h00;
            max_second <= 8'h00;
        end else if (ce) begin
            if (state == prc_pkg::PRC_ACCUM) begin
                max_first <= 8'h00;
                max_second <= 8'h00;
            end else if (state == prc_pkg::PRC_MAXSCAN) begin
                if (!idx[8] && avg > max_first) begin
                    max_first <= avg;
                end
                if (idx[8] && avg > max_second) begin
                    max_second <= avg;
                end
            end
        end
    end

    // ************************************************
    // working map, store and load
    // ************************************************
    always_ff @(posedge mclk) begin
        if (ce) begin
            if (state == prc_pkg::PRC_GAIN) begin
                work_gain[idx] <= gain_calc;
            end else if (ld_wr) begin
                work_gain[ld_widx] <= slot_rd;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            ld_wr <= 1'b0;
            ld_widx <= 9'h000;
        end else if (ce) begin
            ld_wr <= state == prc_pkg::PRC_LOAD;
            ld_widx <= idx;
        end
    end

    // map contents are not reset, so a cleared valid flag stands in for a lost map
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            work_valid <= 1'b0;
            gain_map_ready <= 1'b0;
        end else if (ce) begin
            gain_map_ready <= 1'b0;
            if (state == prc_pkg::PRC_GAIN && idx == `PRC_IDX_LAST) begin
                work_valid <= 1'b1;
                gain_map_ready <= 1'b1;
            end else if (state == prc_pkg::PRC_LDONE) begin
                work_valid <= 1'b1;
            end
        end
    end

    assign store_data = work_valid ? work_gain[idx] : `PRC_GAIN_UNITY;

    prc_slot_store u_slots (
        .mclk(mclk),
        .ce(ce),
        .wr_en(state == prc_pkg::PRC_STORE),
        .wr_slot(op_slot),
        .wr_idx(idx),
        .wr_data(store_data),
        .rd_slot(op_slot),
        .rd_idx(idx),
        .rd_data(slot_rd)
    );

    // ************************************************
    // coefficient adjustments
    // ************************************************
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            coef_scale <= `PRC_SCALE_RESET;
            dark_level <= `PRC_DARK_RESET;
        end else if (ce) begin
            if (gain_map_coefficient_apply) begin
                coef_scale <= prc_pkg::prc_scale_q88(coef_scale, gain_map_coefficient);
            end
            if (dark_offset_coefficient_apply) begin
                dark_level <= prc_pkg::prc_add_sat(dark_level, dark_offset_coefficient);
            end
        end
    end

    // ************************************************
    // pixel stage
    // ************************************************
    always_comb begin
        win_rel = {1'b0, pix_x} - {1'b0, horizontal_window_offset};
        in_win = pix_x >= horizontal_window_offset && win_rel < horizontal_window_width;
        in_roi = correction_window_enable && pix_x >= correction_window_start &&
            pix_x <= correction_window_end;
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s1_valid <= 1'b0;
            s1_data <= 8'h00;
            s1_band <= 1'b0;
            s1_line_end <= 1'b0;
            s1_gain <= `PRC_GAIN_UNITY;
            s1_roi <= 1'b0;
            gain_map_active <= 1'b0;
        end else if (ce) begin
            s1_valid <= pix_valid && in_win;
            s1_data <= pix_data;
            s1_band <= pix_band;
            s1_line_end <= pix_valid && pix_line_end;
            s1_gain <= (response_correction_enable && work_valid) ?
                work_gain[{pix_band, pix_x}] : `PRC_GAIN_UNITY;
            s1_roi <= in_roi;
            gain_map_active <= response_correction_enable && work_valid;
        end
    end

    prc_pixel_path u_path (
        .mclk(mclk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(s1_valid),
        .in_data(s1_data),
        .in_band(s1_band),
        .in_line_end(s1_line_end),
        .in_gain(s1_gain),
        .in_roi(s1_roi),
        .coef_scale(coef_scale),
        .dark_level(dark_level),
        .out_valid(out_valid),
        .out_data(out_data),
        .out_band(out_band),
        .out_line_end(out_line_end)
    );

    // ************************************************
    // checks
    // ************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_cmd_one_shot: assert property (ce && cmd_accepted |=> !cmd_accepted)
        else $error("command accepted twice in a row");
    a_lines_before_set: assert property (ce && state == prc_pkg::PRC_ACCUM && next_state == prc_pkg::PRC_MAXSCAN
        |-> line_cnt == `PRC_LINES_LAST)
        else $error("set made before enough lines");
    a_set_active: assert property (gain_map_ready |-> work_valid && state == prc_pkg::PRC_IDLE)
        else $error("generated set not active");
    a_disable_unity: assert property (ce && !response_correction_enable |=> s1_gain == `PRC_GAIN_UNITY)
        else $error("gain applied while disabled");
    a_manual_target: assert property (state == prc_pkg::PRC_GAIN && !target_level_auto_select
        |-> tgt == flat_field_target_level)
        else $error("manual target not used");
    a_auto_band: assert property (state == prc_pkg::PRC_GAIN && target_level_auto_select && idx[8]
        |-> tgt == max_second)
        else $error("auto target from wrong band");
    a_store_burst: assert property ($rose(state == prc_pkg::PRC_STORE) |-> (state == prc_pkg::PRC_STORE)[*8])
        else $error("store ended early");
    a_load_valid: assert property (ce && state == prc_pkg::PRC_LDONE |=> work_valid && state == prc_pkg::PRC_IDLE)
        else $error("load did not finish");
    a_roi_gate: assert property (ce && !correction_window_enable |=> !s1_roi)
        else $error("coefficient active without window");
    a_reset_lost: assert property ($rose(nrst) |-> !work_valid)
        else $error("working set survived reset");

    c_generate: cover property (gain_map_ready);
    c_store: cover property (state == prc_pkg::PRC_STORE && idx == `PRC_IDX_LAST);
    c_load: cover property (state == prc_pkg::PRC_LDONE);
    c_roi_pixel: cover property (s1_valid && s1_roi && gain_map_active);

endmodule

// [verif/prc_sensor_model.sv]
// Purpose: line-scan sensor model feeding full pixel lines
// Assumes: 256 pixels per line, band toggles every line
// Notes: stops only at a line boundary; idle data toggles so stale values never match
`timescale 1ns/1ps

module prc_sensor_model (
    input wire logic mclk,
    input wire logic run,
    output logic pix_valid,
    output logic [7:0] pix_data,
    output logic pix_band,
    output logic pix_line_end
);
    logic [7:0] x = 8'h00;
    logic [7:0] ln = 8'h00;

    initial begin
        pix_valid = 1'b0;
        pix_data = 8'h5a;
        pix_band = 1'b0;
        pix_line_end = 1'b0;
    end

    // lines keep coming while run is high
    always @(posedge mclk) begin
        if (x == 8'h00 && run !== 1'b1) begin
            pix_valid <= 1'b0;
            pix_line_end <= 1'b0;
            pix_data <= ~pix_data;
        end else begin
            pix_valid <= 1'b1;
            pix_data <= x + ln;
            pix_band <= ln[0];
            pix_line_end <= (x == 8'hff);
            x <= x + 8'h01;
            if (x == 8'hff) begin
                ln <= ln + 8'h01;
            end
        end
    end
endmodule

// [verif/testbench.sv]
// Purpose: self-checking bench for the photo response correction block
// Assumes: ce drops only while no pixels flow; full generation is too long to run here
// Notes: pixel outputs are checked every cycle against a 2-cycle reference pipe
`timescale 1ns/1ps

module testbench;
    logic mclk = 1'b0, nrst = 1'b0, ce = 1'b1, run = 1'b0, chk_on = 1'b0, rdy_seen = 1'b0;
    logic pix_valid, pix_band, pix_line_end, out_valid, out_band, out_line_end;
    logic busy, cmd_accepted, gain_map_ready, gain_map_active;
    logic [7:0] pix_data, out_data, mx = 8'h00, dk = 8'h00;
    logic response_correction_enable = 1'b1, target_level_auto_select = 1'b1, correction_window_enable = 1'b0;
    logic gain_map_generate_cmd = 1'b0, gain_map_store_cmd = 1'b0, gain_map_restore_cmd = 1'b0;
    logic dark_offset_coefficient_apply = 1'b0, gain_map_coefficient_apply = 1'b0;
    logic [3:0] gain_map_slot_select = 4'h0;
    logic [7:0] flat_field_target_level = 8'h80, dark_offset_coefficient = 8'h05, horizontal_window_offset = 8'h00;
    logic [7:0] correction_window_start = 8'h0a, correction_window_end = 8'h14;
    logic [8:0] horizontal_window_width = 9'h100;
    logic [15:0] gain_map_coefficient = 16'h0200, sc = 16'h0100;
    logic [1:0] ev = 2'b00;
    logic [9:0] ed [2];
    int n_errors = 0, compares = 0;

    always #4 mclk = ~mclk;

    prc_top dut (.*);
    prc_sensor_model model (.*);

    // ******************************
    // tasks
    // ******************************
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    function automatic logic [7:0] exp_px(input logic [7:0] p, input logic [7:0] x);
        logic [23:0] t;
        t = {16'h0000, p};
        if (correction_window_enable && x >= correction_window_start && x <= correction_window_end) begin
            t = (t * sc) >> 8;
            t = (t > 24'hff) ? 24'hff : t;
            t = t + dk;
            t = (t > 24'hff) ? 24'hff : t;
        end
        return t[7:0];
    endfunction

    task automatic lines(input int n);
        int k;
        k = 0;
        run <= 1'b1;
        for (int i = 0; i < 4000 && k < n; i++) begin
            @(posedge mclk);
            k += (pix_line_end === 1'b1);
        end
        run <= 1'b0;
        for (int i = 0; i < 600 && pix_valid !== 1'b0; i++) @(posedge mclk);
        repeat (4) @(posedge mclk);
    endtask

    task automatic cmd(input int c, input logic [3:0] s, input int nb);
        int acc, nbz;
        acc = 0;
        nbz = 0;
        gain_map_slot_select <= s;
        @(posedge mclk);
        if (c == 0) gain_map_generate_cmd <= 1'b1;
        if (c == 1) gain_map_store_cmd <= 1'b1;
        if (c == 2) gain_map_restore_cmd <= 1'b1;
        @(posedge mclk);
        {gain_map_generate_cmd, gain_map_store_cmd, gain_map_restore_cmd} <= 3'b000;
        for (int i = 0; i < 600; i++) begin
            @(posedge mclk);
            acc += (cmd_accepted === 1'b1);
            nbz += (busy === 1'b1);
            if (c == 1 && i == 20) gain_map_restore_cmd <= 1'b1;
            if (i == 21) gain_map_restore_cmd <= 1'b0;
            if (nb == 0 ? i > 4 : (nbz > 0 && busy === 1'b0)) break;
        end
        chk("cmd accepted", 16'h0001, 16'(acc));
        if (nb != 0) chk("busy cycles", 16'(nb), 16'(nbz));
    endtask

    task automatic apply(input logic g);
        if (g) gain_map_coefficient_apply <= 1'b1;
        else dark_offset_coefficient_apply <= 1'b1;
        @(posedge mclk);
        {gain_map_coefficient_apply, dark_offset_coefficient_apply} <= 2'b00;
        @(posedge mclk);
    endtask

    task automatic end_sim;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // ******************************
    // pixel monitor
    // ******************************
    always @(posedge mclk) begin
        if (gain_map_ready === 1'b1) rdy_seen = 1'b1;
        if (chk_on) begin
            chk("out_valid", {15'h0, ev[1]}, {15'h0, out_valid});
            chk("out_line_end", {15'h0, ed[1][8]}, {15'h0, out_line_end});
            if (ev[1]) chk("out_data", {8'h00, ed[1][7:0]}, {8'h00, out_data});
            if (ev[1]) chk("out_band", {15'h0, ed[1][9]}, {15'h0, out_band});
        end
        ev[1] = ev[0];
        ed[1] = ed[0];
        ev[0] = pix_valid && mx >= horizontal_window_offset
            && int'(mx) < int'(horizontal_window_offset) + int'(horizontal_window_width);
        ed[0] = {pix_band, pix_valid && pix_line_end, exp_px(pix_data, mx)};
        if (pix_valid) mx = pix_line_end ? 8'h00 : mx + 8'h01;
        if (!nrst) mx = 8'h00;
    end

    initial begin
        repeat (40000) @(posedge mclk);
        n_errors++;
        $display("timeout");
        end_sim();
    end

    // ******************************
    // tests
    // ******************************
    initial begin
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        chk("active after reset", 16'h0, {15'h0, gain_map_active});
        chk_on <= 1'b1;
        lines(2);
        horizontal_window_offset <= 8'h10;
        horizontal_window_width <= 9'h008;
        response_correction_enable <= 1'b0;
        lines(2);
        horizontal_window_offset <= 8'h00;
        horizontal_window_width <= 9'h100;
        response_correction_enable <= 1'b1;
        $display("test window done");
        foreach (ed[j]) begin
            cmd(1, j ? 4'hf : 4'h0, 512);
            cmd(2, j ? 4'hf : 4'h0, 513);
            repeat (2) @(posedge mclk);
            chk("active after load", 16'h1, {15'h0, gain_map_active});
        end
        $display("test slots done");
        apply(1'b1);
        sc = 16'h0200;
        apply(1'b0);
        dk = 8'h05;
        lines(1);
        correction_window_enable <= 1'b1;
        lines(2);
        apply(1'b1);
        sc = 16'h0400;
        lines(1);
        $display("test coefficients done");
        target_level_auto_select <= 1'b0;
        cmd(0, 4'h3, 0);
        chk("busy generating", 16'h1, {15'h0, busy});
        lines(3);
        chk("ready early", 16'h0, {15'h0, rdy_seen});
        chk_on <= 1'b0;
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        sc = 16'h0100;
        dk = 8'h00;
        repeat (2) @(posedge mclk);
        chk("busy after reset", 16'h0, {15'h0, busy});
        chk("set lost", 16'h0, {15'h0, gain_map_active});
        chk_on <= 1'b1;
        cmd(2, 4'hf, 513);
        repeat (2) @(posedge mclk);
        chk("slot survived", 16'h1, {15'h0, gain_map_active});
        // an apply while ce is low must be lost, so the scale stays at unity below
        ce <= 1'b0;
        apply(1'b1);
        ce <= 1'b1;
        lines(1);
        $display("test generate and reset done");
        end_sim();
    end
endmodule
